//--- verilog/ltoc_timers.sv
`timescale 1ns/100ps
// How it works
// RL1 - Each legacy timer holds a 16-bit count written as low and high bytes.
// RL2 - Each legacy timer has its own two mode bits, set independently.
// RL3 - Mode 0 counts 13 bits: high byte plus low byte bits 4..0.
// RL4 - Mode 0 leaves low byte bits 7..5 undefined; software masks them.
// RL5 - 13-bit wrap from all ones sets overflow flag and enabled interrupt.
// RL6 - Counter select 1 counts falling edges of the timer input pin.
// RL7 - Counter select 0 counts system clock or the prescaler source.
// RL8 - Counts only when run and (gate clear or external input active).
// RL9 - Setting run never clears or reloads the count.
// RL10 - Software loads the count before setting run.
// RL11 - Second timer mirrors the first with its own bits and input.
// RL12 - Each legacy timer interrupt gated by its own enable bit.
// RL13 - Third timer split mode flags high and low byte wraps.
// RL14 - High overflow interrupts; low too when low enable set.
// RL15 - Third timer flags stay set until software clears them.
// RL16 - Capture mode counts system clock or system clock over 12.
// RL17 - Capture copies the full count to reload pair and sets high flag.
// RL18 - Capture fires at falling edge of external oscillator over 8.
// RL19 - Software uses 16-bit reload mode and a fast timer clock.
// RL20 - Pin edges are taken from synchronised samples, counted once.
module ltoc_timers (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire ltoc_pkg::ltoc_leg_cfg_t timer_a_cfg,
  input  wire ltoc_pkg::ltoc_leg_cfg_t timer_b_cfg,
  input  wire ltoc_pkg::ltoc_c_cfg_t   timer_c_cfg,
  input  wire logic [1:0]             clock_scale,
  input  wire ltoc_pkg::ltoc_wr_t      sw_wr,
  input  wire logic                   timer_a_input_pin,
  input  wire logic                   timer_b_input_pin,
  input  wire logic                   ext_irq_a_input,
  input  wire logic                   ext_irq_b_input,
  input  wire logic                   ext_osc_pin,
  output logic [7:0]                  timer_a_low_byte,
  output logic [7:0]                  timer_a_high_byte,
  output logic                        timer_a_overflow_flag,
  output logic                        timer_a_irq,
  output logic [7:0]                  timer_b_low_byte,
  output logic [7:0]                  timer_b_high_byte,
  output logic                        timer_b_overflow_flag,
  output logic                        timer_b_irq,
  output logic [7:0]                  timer_c_low_byte,
  output logic [7:0]                  timer_c_high_byte,
  output logic [7:0]                  timer_c_reload_low,
  output logic [7:0]                  timer_c_reload_high,
  output logic                        timer_c_high_overflow_flag,
  output logic                        timer_c_low_overflow_flag,
  output logic                        timer_c_irq
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Step a legacy count; bit 16 flags a wrap
  function automatic logic [16:0] ltoc_step(
    input logic [1:0]  mode,
    input logic [15:0] c
  );
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0]  s8;
    s13 = {1'b0, c[15:8], c[4:0]} + 14'h0001;
    s16 = {1'b0, c} + 17'h00001;
    s8  = {1'b0, c[7:0]} + 9'h001;
    case (mode)
      ltoc_pkg::MODE_13BIT: begin
        ltoc_step = {s13[13], s13[12:5], c[7:5], s13[4:0]}; // RL3 RL4 RL5
      end
      ltoc_pkg::MODE_16BIT: begin
        ltoc_step = s16;
      end
      ltoc_pkg::MODE_8RLD: begin
        ltoc_step = {s8[8], c[15:8], (s8[8] ? c[15:8] : s8[7:0])};
      end
      default: begin
        ltoc_step = {1'b0, c};
      end
    endcase
  endfunction : ltoc_step

  // Tick of a legacy timer
  function automatic logic ltoc_tick(
    input ltoc_pkg::ltoc_leg_cfg_t cfg,
    input logic                    pin_fall,
    input logic                    irq_level,
    input logic                    scale_tick
  );
    logic active;
    logic src;
    active = cfg.ext_irq_polarity ? irq_level : ~irq_level;
    if (cfg.counter_timer_select) begin
      src = pin_fall; // RL6
    end else begin
      src = cfg.clock_select ? 1'b1 : scale_tick; // RL7
    end
    ltoc_tick = cfg.run & (~cfg.gate | active) & src; // RL8
  endfunction : ltoc_tick

  // ----------------------------------------
  // State
  // ----------------------------------------
  ltoc_pkg::ltoc_state_t st_q;
  ltoc_pkg::ltoc_state_t st_d;

  logic [4:0]  fall;
  logic        osc_tick;
  logic        div4_tick;
  logic        div12_tick;
  logic        div48_tick;
  logic        scale_tick;
  logic        tick_a;
  logic        tick_b;
  logic        tick_c;
  logic [16:0] nxt_a;
  logic [16:0] nxt_b;
  logic [16:0] nxt_c;
  logic [8:0]  nxt_cl;
  logic [8:0]  nxt_ch;
  logic        set_ch;
  logic        set_cl;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    // Two-stage synchronisers plus edge stage
    st_d.s1 = {ext_osc_pin, ext_irq_b_input, ext_irq_a_input,
               timer_b_input_pin, timer_a_input_pin};
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    fall = st_q.s3 & ~st_q.s2; // RL20

    // Prescaler over one 48-cycle period
    st_d.pre = (st_q.pre == ltoc_pkg::PRE_DIV48 - 6'h01) ? 6'h00 : st_q.pre + 6'h01;
    div4_tick  = (st_q.pre[1:0] == 2'h0);
    div12_tick = (st_q.pre == 6'h00) || (st_q.pre == ltoc_pkg::PRE_DIV12)
                 || (st_q.pre == ltoc_pkg::PRE_AT24) || (st_q.pre == ltoc_pkg::PRE_AT36);
    div48_tick = (st_q.pre == 6'h00);

    // Oscillator over 8: one tick per eight falling edges
    osc_tick = 1'b0;
    if (fall[ltoc_pkg::SYNC_OSC]) begin
      st_d.osc_cnt = st_q.osc_cnt + 3'h1;
      osc_tick = (st_q.osc_cnt == ltoc_pkg::OSC_LAST); // RL18
    end

    case (clock_scale)
      ltoc_pkg::SCALE_DIV12: begin
        scale_tick = div12_tick;
      end
      ltoc_pkg::SCALE_DIV4: begin
        scale_tick = div4_tick;
      end
      ltoc_pkg::SCALE_DIV48: begin
        scale_tick = div48_tick;
      end
      default: begin
        scale_tick = osc_tick;
      end
    endcase

    // Legacy timers
    tick_a = ltoc_tick(timer_a_cfg, fall[ltoc_pkg::SYNC_TA_PIN],
                       st_q.s2[ltoc_pkg::SYNC_IRQ_A], scale_tick);
    tick_b = ltoc_tick(timer_b_cfg, fall[ltoc_pkg::SYNC_TB_PIN],
                       st_q.s2[ltoc_pkg::SYNC_IRQ_B], scale_tick); // RL11
    nxt_a = ltoc_step(timer_a_cfg.mode_select_bits, st_q.cnt_a); // RL2
    nxt_b = ltoc_step(timer_b_cfg.mode_select_bits, st_q.cnt_b); // RL2
    if (tick_a) begin
      st_d.cnt_a = nxt_a[15:0]; // RL9
    end
    if (tick_b) begin
      st_d.cnt_b = nxt_b[15:0];
    end
    if (sw_wr.a_low_wr) begin
      st_d.cnt_a[7:0] = sw_wr.data; // RL1
    end
    if (sw_wr.a_high_wr) begin
      st_d.cnt_a[15:8] = sw_wr.data; // RL1
    end
    if (sw_wr.b_low_wr) begin
      st_d.cnt_b[7:0] = sw_wr.data;
    end
    if (sw_wr.b_high_wr) begin
      st_d.cnt_b[15:8] = sw_wr.data;
    end
    // Set beats clear
    st_d.flag_a = (st_q.flag_a & ~sw_wr.a_flag_clr) | (tick_a & nxt_a[16]); // RL5
    st_d.flag_b = (st_q.flag_b & ~sw_wr.b_flag_clr) | (tick_b & nxt_b[16]);
    st_d.irq_a  = timer_a_cfg.irq_enable & st_d.flag_a; // RL12
    st_d.irq_b  = timer_b_cfg.irq_enable & st_d.flag_b; // RL12

    // Third timer clock
    if (timer_c_cfg.timer_c_clock_select) begin
      tick_c = 1'b1; // RL16
    end else if (timer_c_cfg.timer_c_ext_clock_select && !timer_c_cfg.capture_mode) begin
      tick_c = osc_tick;
    end else begin
      tick_c = div12_tick; // RL16
    end
    tick_c = tick_c & timer_c_cfg.run;

    nxt_c  = {1'b0, st_q.cnt_c} + 17'h00001;
    nxt_cl = {1'b0, st_q.cnt_c[7:0]} + 9'h001;
    nxt_ch = {1'b0, st_q.cnt_c[15:8]} + 9'h001;
    set_ch = 1'b0;
    set_cl = 1'b0;
    if (tick_c) begin
      if (timer_c_cfg.split_mode) begin
        st_d.cnt_c[7:0]  = nxt_cl[8] ? st_q.rld_c[7:0] : nxt_cl[7:0];
        st_d.cnt_c[15:8] = nxt_ch[8] ? st_q.rld_c[15:8] : nxt_ch[7:0];
        set_cl = nxt_cl[8]; // RL13
        set_ch = nxt_ch[8]; // RL13
      end else begin
        if (nxt_c[16] && !timer_c_cfg.capture_mode) begin
          st_d.cnt_c = st_q.rld_c;
        end else begin
          st_d.cnt_c = nxt_c[15:0];
        end
        set_ch = nxt_c[16];
      end
    end

    // Capture of the running count
    if (timer_c_cfg.capture_mode && osc_tick) begin
      st_d.rld_c = st_q.cnt_c; // RL17
      set_ch = 1'b1; // RL17
    end
    if (sw_wr.c_low_wr) begin
      st_d.cnt_c[7:0] = sw_wr.data;
    end
    if (sw_wr.c_high_wr) begin
      st_d.cnt_c[15:8] = sw_wr.data;
    end
    if (sw_wr.c_reload_low_wr) begin
      st_d.rld_c[7:0] = sw_wr.data;
    end
    if (sw_wr.c_reload_high_wr) begin
      st_d.rld_c[15:8] = sw_wr.data;
    end

    // Flags cleared only by software, set wins
    st_d.flag_ch = (st_q.flag_ch & ~sw_wr.c_high_flag_clr) | set_ch; // RL15
    st_d.flag_cl = (st_q.flag_cl & ~sw_wr.c_low_flag_clr) | set_cl; // RL15
    st_d.irq_c = timer_c_cfg.irq_enable
                 & (st_d.flag_ch | (timer_c_cfg.timer_c_low_irq_enable & st_d.flag_cl)); // RL14
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q.pre     <= 6'h00;
      st_q.osc_cnt <= 3'h0;
      st_q.s1      <= ltoc_pkg::SYNC_RESET;
      st_q.s2      <= ltoc_pkg::SYNC_RESET;
      st_q.s3      <= ltoc_pkg::SYNC_RESET;
      st_q.cnt_a   <= ltoc_pkg::CNT_RESET;
      st_q.cnt_b   <= ltoc_pkg::CNT_RESET;
      st_q.flag_a  <= 1'b0;
      st_q.flag_b  <= 1'b0;
      st_q.irq_a   <= 1'b0;
      st_q.irq_b   <= 1'b0;
      st_q.cnt_c   <= ltoc_pkg::CNT_RESET;
      st_q.rld_c   <= ltoc_pkg::CNT_RESET;
      st_q.flag_ch <= 1'b0;
      st_q.flag_cl <= 1'b0;
      st_q.irq_c   <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign timer_a_low_byte           = st_q.cnt_a[7:0];
  assign timer_a_high_byte          = st_q.cnt_a[15:8];
  assign timer_a_overflow_flag      = st_q.flag_a;
  assign timer_a_irq                = st_q.irq_a;
  assign timer_b_low_byte           = st_q.cnt_b[7:0];
  assign timer_b_high_byte          = st_q.cnt_b[15:8];
  assign timer_b_overflow_flag      = st_q.flag_b;
  assign timer_b_irq                = st_q.irq_b;
  assign timer_c_low_byte           = st_q.cnt_c[7:0];
  assign timer_c_high_byte          = st_q.cnt_c[15:8];
  assign timer_c_reload_low         = st_q.rld_c[7:0];
  assign timer_c_reload_high        = st_q.rld_c[15:8];
  assign timer_c_high_overflow_flag = st_q.flag_ch;
  assign timer_c_low_overflow_flag  = st_q.flag_cl;
  assign timer_c_irq                = st_q.irq_c;

endmodule : ltoc_timers

//--- verilog/ltoc_pkg.sv
package ltoc_pkg;

  // ----------------------------------------
  // Mode and scale encodings
  // ----------------------------------------
  localparam logic [1:0] MODE_13BIT  = 2'h0;
  localparam logic [1:0] MODE_16BIT  = 2'h1;
  localparam logic [1:0] MODE_8RLD   = 2'h2;
  localparam logic [1:0] MODE_HALT   = 2'h3;

  localparam logic [1:0] SCALE_DIV12 = 2'h0;
  localparam logic [1:0] SCALE_DIV4  = 2'h1;
  localparam logic [1:0] SCALE_DIV48 = 2'h2;
  localparam logic [1:0] SCALE_OSC8  = 2'h3;

  // ----------------------------------------
  // Timing counts
  // ----------------------------------------
  localparam logic [5:0] PRE_DIV4    = 6'h04;
  localparam logic [5:0] PRE_DIV12   = 6'h0C;
  localparam logic [5:0] PRE_DIV48   = 6'h30;
  localparam logic [5:0] PRE_AT24    = 6'h18;
  localparam logic [5:0] PRE_AT36    = 6'h24;
  localparam logic [2:0] OSC_LAST    = 3'h7;

  // ----------------------------------------
  // Reset values and field positions
  // ----------------------------------------
  localparam logic [15:0] CNT_RESET  = 16'h0000;
  localparam logic [4:0]  SYNC_RESET = 5'h00;
  localparam int SYNC_TA_PIN  = 0;
  localparam int SYNC_TB_PIN  = 1;
  localparam int SYNC_IRQ_A   = 2;
  localparam int SYNC_IRQ_B   = 3;
  localparam int SYNC_OSC     = 4;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic       run;
    logic       gate;
    logic [1:0] mode_select_bits;
    logic       counter_timer_select;
    logic       clock_select;
    logic       irq_enable;
    logic       ext_irq_polarity;
  } ltoc_leg_cfg_t;

  typedef struct packed {
    logic run;
    logic split_mode;
    logic capture_mode;
    logic timer_c_clock_select;
    logic timer_c_ext_clock_select;
    logic irq_enable;
    logic timer_c_low_irq_enable;
  } ltoc_c_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic       a_low_wr;
    logic       a_high_wr;
    logic       b_low_wr;
    logic       b_high_wr;
    logic       c_low_wr;
    logic       c_high_wr;
    logic       c_reload_low_wr;
    logic       c_reload_high_wr;
    logic       a_flag_clr;
    logic       b_flag_clr;
    logic       c_high_flag_clr;
    logic       c_low_flag_clr;
  } ltoc_wr_t;

  typedef struct packed {
    logic [5:0]  pre;
    logic [2:0]  osc_cnt;
    logic [4:0]  s1;
    logic [4:0]  s2;
    logic [4:0]  s3;
    logic [15:0] cnt_a;
    logic [15:0] cnt_b;
    logic        flag_a;
    logic        flag_b;
    logic        irq_a;
    logic        irq_b;
    logic [15:0] cnt_c;
    logic [15:0] rld_c;
    logic        flag_ch;
    logic        flag_cl;
    logic        irq_c;
  } ltoc_state_t;

endpackage : ltoc_pkg

//--- testbench/ltoc_timers_monitor.sv
`timescale 1ns/100ps
module ltoc_timers_monitor (
  input wire logic                    sys_clk,
  input wire logic                    rst,
  input wire ltoc_pkg::ltoc_leg_cfg_t timer_a_cfg,
  input wire ltoc_pkg::ltoc_c_cfg_t   timer_c_cfg,
  input wire ltoc_pkg::ltoc_wr_t      sw_wr,
  input wire logic [7:0]              timer_a_low_byte,
  input wire logic [7:0]              timer_a_high_byte,
  input wire logic                    timer_a_overflow_flag,
  input wire logic                    timer_a_irq,
  input wire logic [7:0]              timer_c_reload_low,
  input wire logic [7:0]              timer_c_reload_high,
  input wire logic                    timer_c_high_overflow_flag,
  input wire logic                    timer_c_low_overflow_flag,
  input wire logic                    timer_c_irq
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [12:0] cnt13;
  logic        a_wr;
  logic        a_ok;
  assign cnt13 = {timer_a_high_byte, timer_a_low_byte[4:0]};
  assign a_wr  = sw_wr.a_low_wr | sw_wr.a_high_wr;
  assign a_ok  = timer_a_cfg.run & ~timer_a_cfg.gate & ~timer_a_cfg.counter_timer_select & timer_a_cfg.clock_select
               & (timer_a_cfg.mode_select_bits == ltoc_pkg::MODE_13BIT) & ~a_wr;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_run3; a_ok && $past(a_ok) && $past(a_ok, 2); endsequence
  sequence s_wrap; $past(cnt13) == 13'h1FFF && cnt13 == 13'h0000 && $past(a_ok); endsequence
  property p_a_write; sw_wr.a_low_wr |=> timer_a_low_byte == $past(sw_wr.data); endproperty
  property p_a_hold; !timer_a_cfg.run && $past(!timer_a_cfg.run) && !a_wr |=> $stable(cnt13); endproperty
  property p_a_inc; s_run3 |-> cnt13 == $past(cnt13) + 13'h0001; endproperty
  property p_a_wrap; s_wrap |-> timer_a_overflow_flag && timer_a_irq == $past(timer_a_cfg.irq_enable); endproperty
  property p_a_sticky; timer_a_overflow_flag && !sw_wr.a_flag_clr |=> timer_a_overflow_flag; endproperty
  property p_ch_sticky; timer_c_high_overflow_flag && !sw_wr.c_high_flag_clr |=> timer_c_high_overflow_flag; endproperty
  property p_cl_sticky; timer_c_low_overflow_flag && !sw_wr.c_low_flag_clr |=> timer_c_low_overflow_flag; endproperty
  property p_c_irq; $rose(timer_c_high_overflow_flag) && $past(timer_c_cfg.irq_enable) |-> timer_c_irq; endproperty
  property p_cap;
    timer_c_cfg.capture_mode && $past(timer_c_cfg.capture_mode)
    && !$past(sw_wr.c_reload_low_wr | sw_wr.c_reload_high_wr)
    && $changed({timer_c_reload_high, timer_c_reload_low}) |-> timer_c_high_overflow_flag;
  endproperty
  a_a_write: assert property (p_a_write) else $error("low byte write lost");
  a_a_hold: assert property (p_a_hold) else $error("count moved while stopped");
  a_a_inc: assert property (p_a_inc) else $error("13-bit count did not step");
  a_a_wrap: assert property (p_a_wrap) else $error("wrap without flag or irq");
  a_a_sticky: assert property (p_a_sticky) else $error("overflow flag dropped");
  a_ch_sticky: assert property (p_ch_sticky) else $error("high flag dropped");
  a_cl_sticky: assert property (p_cl_sticky) else $error("low flag dropped");
  a_c_irq: assert property (p_c_irq) else $error("high overflow without irq");
  a_cap: assert property (p_cap) else $error("capture without high flag");
endmodule : ltoc_timers_monitor

bind ltoc_timers ltoc_timers_monitor u_mon (.sys_clk, .rst, .timer_a_cfg, .timer_c_cfg, .sw_wr, .timer_a_low_byte,
  .timer_a_high_byte, .timer_a_overflow_flag, .timer_a_irq, .timer_c_reload_low, .timer_c_reload_high,
  .timer_c_high_overflow_flag, .timer_c_low_overflow_flag, .timer_c_irq);

//--- testbench/ltoc_timers_tb.sv
`timescale 1ns/100ps
module ltoc_timers_tb;
  logic                    sys_clk;
  logic                    rst;
  ltoc_pkg::ltoc_leg_cfg_t cfg [2];
  ltoc_pkg::ltoc_c_cfg_t   cfg_c;
  ltoc_pkg::ltoc_wr_t      wr;
  logic [1:0]              scale;
  logic                    pin [2];
  logic                    eirq [2];
  logic                    osc;
  logic                    osc_en;
  logic [7:0]              lo [2];
  logic [7:0]              hi [2];
  logic                    flg [2];
  logic                    irq [2];
  logic [7:0]              r_lo, r_hi;
  logic [7:0]              c_lo, c_hi;
  logic                    fh, fl, c_irq;
  int                      oc;
  int                      n_mismatch;
  int                      check_count;

  ltoc_timers dut (.sys_clk(sys_clk), .rst(rst), .timer_a_cfg(cfg[0]), .timer_b_cfg(cfg[1]), .timer_c_cfg(cfg_c),
    .clock_scale(scale), .sw_wr(wr), .timer_a_input_pin(pin[0]), .timer_b_input_pin(pin[1]),
    .ext_irq_a_input(eirq[0]), .ext_irq_b_input(eirq[1]), .ext_osc_pin(osc),
    .timer_a_low_byte(lo[0]), .timer_a_high_byte(hi[0]), .timer_a_overflow_flag(flg[0]), .timer_a_irq(irq[0]),
    .timer_b_low_byte(lo[1]), .timer_b_high_byte(hi[1]), .timer_b_overflow_flag(flg[1]), .timer_b_irq(irq[1]),
    .timer_c_low_byte(c_lo), .timer_c_high_byte(c_hi), .timer_c_reload_low(r_lo), .timer_c_reload_high(r_hi),
    .timer_c_high_overflow_flag(fh), .timer_c_low_overflow_flag(fl), .timer_c_irq(c_irq));

  // ----------------------------------------
  // Clock, oscillator and helpers
  // ----------------------------------------
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (osc_en) begin
    #1;
    oc <= (oc == 11) ? 0 : oc + 1;
    if (oc == 11) osc <= ~osc;
  end

  task tk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tk
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task w(input int s, input logic [7:0] d);
    wr = ltoc_pkg::ltoc_wr_t'({d, 12'(12'h800 >> s)});
    tk(1);
    wr = '0;
    tk(1);
  endtask : w
  task ld(input int i, input logic [15:0] v);
    w(2 * i, v[7:0]);
    w(2 * i + 1, v[15:8]);
  endtask : ld
  function automatic logic [15:0] c13(input int i);
    return {3'h0, hi[i], lo[i][4:0]};
  endfunction : c13
  task wf;
    int k;
    k = 0;
    while (fh !== 1'b1 && k < 400) begin
      tk(1);
      k++;
    end
    chk("capture flag", {15'h0000, fh}, 16'h0001);
  endtask : wf
  task summarize;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    chk("reset state", {fh, fl, c_irq, flg[0], irq[0], flg[1], irq[1], lo[0]}, 16'h0000);
    ld(0, 16'h1234);
    chk("a bytes", {hi[0], lo[0]}, 16'h1234);
    ld(1, 16'hABCD);
    chk("b bytes", {hi[1], lo[1]}, 16'hABCD);
    $display("test reset done");
  endtask : t_reset
  task t_mode0(input int i);
    for (int e = 0; e < 2; e++) begin
      cfg[i] = '0;
      cfg[i].clock_select = 1'b1;
      cfg[i].irq_enable = e[0];
      ld(i, 16'hFF1E);
      cfg[i].run = 1'b1;
      tk(4);
      cfg[i].run = 1'b0;
      tk(6);
      chk("count13", c13(i), 16'h0002);
      chk("flag irq", {flg[i], irq[i]}, {1'b1, e[0]});
      w(8 + i, 8'h00);
      chk("flag clear", {flg[i], irq[i]}, 16'h0000);
    end
    $display("test mode0 done");
  endtask : t_mode0
  task t_gate(input int i);
    for (int p = 0; p < 2; p++) begin
      cfg[i] = '0;
      cfg[i].clock_select = 1'b1;
      cfg[i].gate = 1'b1;
      cfg[i].ext_irq_polarity = p[0];
      eirq[i] = ~p[0];
      ld(i, 16'h0000);
      cfg[i].run = 1'b1;
      tk(10);
      chk("gated", c13(i), 16'h0000);
      eirq[i] = p[0];
      tk(6);
      eirq[i] = ~p[0];
      tk(8);
      chk("gate open", c13(i), 16'h0006);
      cfg[i].run = 1'b0;
    end
    $display("test gate done");
  endtask : t_gate
  task t_pin(input int i);
    cfg[i] = '0;
    cfg[i].counter_timer_select = 1'b1;
    ld(i, 16'h0000);
    cfg[i].run = 1'b1;
    repeat (3) begin
      pin[i] = 1'b1;
      tk(3);
      pin[i] = 1'b0;
      tk(3);
    end
    tk(4);
    chk("pin falls", c13(i), 16'h0003);
    cfg[i].run = 1'b0;
    $display("test pin done");
  endtask : t_pin
  task t_modes;
    cfg[0] = '0;
    cfg[1] = '0;
    cfg[0].clock_select = 1'b1;
    cfg[1].clock_select = 1'b1;
    cfg[0].mode_select_bits = ltoc_pkg::MODE_16BIT;
    cfg[1].mode_select_bits = ltoc_pkg::MODE_HALT;
    ld(0, 16'hFFFF);
    ld(1, 16'h1234);
    cfg[0].run = 1'b1;
    cfg[1].run = 1'b1;
    tk(2);
    cfg[0].run = 1'b0;
    cfg[1].run = 1'b0;
    tk(2);
    chk("mode 16bit", {hi[0], lo[0]}, 16'h0001);
    chk("mode halt", {hi[1], lo[1]}, 16'h1234);
    chk("mode flags", {flg[0], flg[1]}, 16'h0002);
    w(8, 8'h00);
    cfg[0].mode_select_bits = ltoc_pkg::MODE_8RLD;
    ld(0, 16'h80FE);
    cfg[0].run = 1'b1;
    tk(3);
    cfg[0].run = 1'b0;
    tk(2);
    chk("mode reload", {hi[0], lo[0]}, 16'h8081);
    chk("reload flag", {15'h0000, flg[0]}, 16'h0001);
    w(8, 8'h00);
    $display("test modes done");
  endtask : t_modes
  task t_scale;
    logic [15:0] e [3];
    e = '{16'h0008, 16'h0018, 16'h0002};
    cfg[0] = '0;
    for (int s = 0; s < 3; s++) begin
      scale = s[1:0];
      ld(0, 16'h0000);
      cfg[0].run = 1'b1;
      tk(96);
      cfg[0].run = 1'b0;
      tk(4);
      chk("scaled count", c13(0), e[s]);
    end
    $display("test scale done");
  endtask : t_scale
  task t_split;
    cfg_c = '0;
    cfg_c.split_mode = 1'b1;
    cfg_c.timer_c_clock_select = 1'b1;
    cfg_c.irq_enable = 1'b1;
    for (int le = 0; le < 2; le++) begin
      cfg_c.timer_c_low_irq_enable = le[0];
      ld(3, 16'h0000);
      ld(2, 16'h00FF);
      cfg_c.run = 1'b1;
      tk(1);
      cfg_c.run = 1'b0;
      tk(3);
      chk("low wrap", {fh, fl, c_irq}, {2'b01, le[0]});
      chk("split count", {c_hi, c_lo}, 16'h0100);
      tk(10);
      chk("low sticky", {15'h0000, fl}, 16'h0001);
      w(11, 8'h00);
      ld(2, 16'hFF00);
      cfg_c.run = 1'b1;
      tk(1);
      cfg_c.run = 1'b0;
      tk(3);
      chk("high wrap", {fh, fl, c_irq}, 16'h0005);
      chk("split reload", {c_hi, c_lo}, 16'h0001);
      w(10, 8'h00);
      chk("flags clear", {fh, fl, c_irq}, 16'h0000);
    end
    $display("test split done");
  endtask : t_split
  task t_capture;
    logic [15:0] r1;
    logic [15:0] a1;
    cfg_c = '0;
    cfg_c.capture_mode = 1'b1;
    cfg_c.run = 1'b1;
    cfg[0] = '0;
    scale = 2'h3;
    ld(0, 16'h0000);
    cfg[0].run = 1'b1;
    osc_en = 1'b1;
    for (int s = 0; s < 2; s++) begin
      cfg_c.timer_c_clock_select = s[0];
      wf;
      w(10, 8'h00);
      wf;
      r1 = {r_hi, r_lo};
      a1 = c13(0);
      w(10, 8'h00);
      wf;
      chk("capture gap", {r_hi, r_lo} - r1, s ? 16'h00C0 : 16'h0010);
      chk("osc scale", c13(0) - a1, 16'h0001);
    end
    cfg[0].run = 1'b0;
    cfg_c = '0;
    cfg_c.timer_c_ext_clock_select = 1'b1;
    ld(3, 16'h1234);
    ld(2, 16'hFFFF);
    w(10, 8'h00);
    cfg_c.run = 1'b1;
    wf;
    chk("osc reload", {c_hi, c_lo}, 16'h1234);
    cfg_c.run = 1'b0;
    osc_en = 1'b0;
    $display("test capture done");
  endtask : t_capture

  initial begin
    rst = 1'b1;
    cfg[0] = '0;
    cfg[1] = '0;
    cfg_c = '0;
    wr = '0;
    scale = 2'h0;
    pin = '{1'b0, 1'b0};
    eirq = '{1'b0, 1'b0};
    osc = 1'b0;
    osc_en = 1'b0;
    oc = 0;
    n_mismatch = 0;
    check_count = 0;
    tk(12);
    rst = 1'b0;
    tk(1);
    t_reset;
    for (int i = 0; i < 2; i++) begin
      t_mode0(i);
      t_gate(i);
      t_pin(i);
    end
    t_modes;
    t_scale;
    t_split;
    t_capture;
    summarize;
  end
  initial begin
    #5000000;
    n_mismatch++;
    summarize;
  end
endmodule : ltoc_timers_tb
